// ==== core/ptb_pkg.sv ====
/*
  Shared constants and carriers for the PWM time-base counter.
  Assumes a 32-bit APB register bus and one 200 MHz system clock.
*/
package ptb_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h00;
  localparam logic [7:0] IDX_STATUS = 8'h02;
  localparam logic [7:0] IDX_FINE = 8'h04;
  localparam logic [7:0] IDX_PHASE = 8'h06;
  localparam logic [7:0] IDX_COUNT = 8'h08;
  localparam logic [7:0] IDX_PERIOD = 8'h0A;
  localparam logic [7:0] IDX_CMPB = 8'h10;
  localparam logic [7:0] IDX_INT_STATUS = 8'h12;
  localparam logic [7:0] IDX_INT_MASK = 8'h14;
  // Control field positions
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_PHASE_LOAD_ENABLE = 2;
  localparam int CTL_PERIOD_LOAD_SELECT = 3;
  localparam int CTL_SYNCSEL_LSB = 4;
  localparam int CTL_SWSYNC = 6;
  localparam int CTL_DIV_LSB = 7;
  // Interrupt status bit positions
  localparam int INT_ZERO = 0;
  localparam int INT_PERIOD = 1;
  localparam int INT_SYNC = 2;
  // Reset values
  localparam logic [15:0] CONTROL_RST = 16'h0003;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [2:0] INT_RST = 3'h0;
  localparam logic [5:0] DIV_RST = 6'h00;

  typedef enum logic [1:0] {
    MODE_UP,
    MODE_DOWN,
    MODE_UPDOWN,
    MODE_FREEZE
  } ptb_mode_type;

  typedef enum logic [1:0] {
    SYNCO_PASS,
    SYNCO_ZERO,
    SYNCO_CMPB,
    SYNCO_OFF
  } ptb_synco_type;

  typedef struct packed {
    logic [2:0] spare;
    logic [5:0] prescale;
    logic sw_sync;
    ptb_synco_type sync_out_source_select;
    logic period_load_select;
    logic phase_load_enable;
    ptb_mode_type count_direction_mode;
  } ptb_ctrl_type;

  typedef struct packed {
    logic sync;
    logic period;
    logic zero;
  } ptb_evt_type;
endpackage

// ==== core/ptb_time_base.sv ====
/*
  PWM time-base counter with APB register slave, prescaler, shadowed
  period, phase sync chain and a masked interrupt.
  Assumes APB master on pclk; sync_in_pulse is synchronous to pclk.
*/
`timescale 1ns/1ps

module ptb_time_base import ptb_pkg::*; #(
  parameter bit HAS_FINE_EXT = 1'b1
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic sync_in_pulse, // Sync from previous module
  output logic sync_out_pulse, // Sync to next module
  output logic zero_match_event, // Counter equals zero
  output logic period_match_event, // Counter equals active period
  output logic compare_b_match_event, // Counter equals compare B
  output logic count_dir_up, // Current counting direction
  output logic irq // Level interrupt
);

  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx[5:0], 2'b00};
  endfunction

  ptb_ctrl_type ctrl_q;
  logic [15:0] status_q, fine_q, phase_q, cnt_q, cnt_d, prd_sh_q, prd_act_q, cmpb_q;
  logic [2:0] int_q, int_d, mask_q;
  logic [5:0] div_q;
  logic dir_up_q, dir_up_d, sync_pend_q, sync_out_q;
  logic [31:0] rdata_q;

  // Bus decode
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_ctl = paddr == byte_addr(IDX_CONTROL);
  wire hit_sts = paddr == byte_addr(IDX_STATUS);
  wire hit_fine = (paddr == byte_addr(IDX_FINE)) & HAS_FINE_EXT;
  wire hit_res = (paddr == byte_addr(IDX_FINE)) & !HAS_FINE_EXT;
  wire hit_phs = paddr == byte_addr(IDX_PHASE);
  wire hit_cnt = paddr == byte_addr(IDX_COUNT);
  wire hit_prd = paddr == byte_addr(IDX_PERIOD);
  wire hit_cmpb = paddr == byte_addr(IDX_CMPB);
  wire hit_int = paddr == byte_addr(IDX_INT_STATUS);
  wire hit_mask = paddr == byte_addr(IDX_INT_MASK);
  wire mapped = hit_ctl | hit_sts | hit_fine | hit_res | hit_phs | hit_cnt | hit_prd
    | hit_cmpb | hit_int | hit_mask;
  wire wr_ctl = wr & hit_ctl;
  wire wr_cnt = wr & hit_cnt;
  wire wr_prd = wr & hit_prd;
  wire wr_int = wr & hit_int;
  wire wr_sts = wr & hit_sts;

  assign pready = 1'b1;
  assign pslverr = acc & !mapped;
  assign prdata = rdata_q;

  // Prescaler: one tick every prescale+1 system clocks
  // Compare is >= so lowering prescale mid-count cannot stall for 64 clocks
  wire tick = div_q >= ctrl_q.prescale;
  wire freeze = ctrl_q.count_direction_mode == MODE_FREEZE;

  // Sync acceptance; software force counts as a sync
  wire sw_sync = wr_ctl & pwdata[CTL_SWSYNC];
  wire sync_evt = ctrl_q.phase_load_enable & (sync_in_pulse | sw_sync);
  wire load_phase = tick & sync_pend_q;

  // Next count
  always_comb begin
    cnt_d = cnt_q;
    dir_up_d = dir_up_q;
    if (load_phase) begin
      cnt_d = phase_q;
    end else if (tick) begin
      case (ctrl_q.count_direction_mode)
        MODE_UP: begin
          cnt_d = (cnt_q == prd_act_q) ? 16'h0000 : cnt_q + 16'h0001;
          dir_up_d = 1'b1;
        end
        MODE_DOWN: begin
          cnt_d = (cnt_q == 16'h0000) ? prd_act_q : cnt_q - 16'h0001;
          dir_up_d = 1'b0;
        end
        MODE_UPDOWN: begin
          if (dir_up_q && cnt_q >= prd_act_q) begin
            dir_up_d = 1'b0;
            cnt_d = cnt_q - 16'h0001;
          end else if (!dir_up_q && cnt_q == 16'h0000) begin
            dir_up_d = 1'b1;
            cnt_d = 16'h0001;
          end else begin
            cnt_d = dir_up_q ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
          end
        end
        default: cnt_d = cnt_q;
      endcase
    end
    if (wr_cnt) begin
      cnt_d = pwdata[15:0];
    end
  end

  // Events on each stepped count
  wire step = tick & !freeze & !wr_cnt;
  wire zero_hit = step & cnt_d == 16'h0000;
  wire prd_hit = step & cnt_d == prd_act_q;
  wire cmpb_hit = step & cnt_d == cmpb_q;
  ptb_evt_type evt;
  assign evt = '{sync: sync_evt, period: prd_hit, zero: zero_hit};

  // Sync out source mux
  logic sync_out_d;
  always_comb begin
    case (ctrl_q.sync_out_source_select)
      SYNCO_PASS: sync_out_d = sync_in_pulse;
      SYNCO_ZERO: sync_out_d = zero_hit;
      SYNCO_CMPB: sync_out_d = cmpb_hit;
      default: sync_out_d = 1'b0;
    endcase
  end

  // Sticky flags: set wins over write-one clear
  assign int_d = (int_q & ~(wr_int ? pwdata[2:0] : 3'h0)) | evt;

  // Read mux
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (hit_ctl) rd_mux = ctrl_q;
    if (hit_sts) rd_mux = {status_q[15:2], status_q[1], dir_up_q};
    if (hit_fine) rd_mux = fine_q;
    if (hit_phs) rd_mux = phase_q;
    if (hit_cnt) rd_mux = cnt_q;
    if (hit_prd) rd_mux = prd_sh_q;
    if (hit_cmpb) rd_mux = cmpb_q;
    if (hit_int) rd_mux = {13'h0, int_q};
    if (hit_mask) rd_mux = {13'h0, mask_q};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CONTROL_RST;
      fine_q <= WORD_RST;
      phase_q <= WORD_RST;
      cmpb_q <= WORD_RST;
      mask_q <= INT_RST;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (wr_ctl) ctrl_q <= {pwdata[15:7], 1'b0, pwdata[5:0]};
      if (wr & hit_fine) fine_q <= pwdata[15:0];
      if (wr & hit_phs) phase_q <= pwdata[15:0];
      if (wr & hit_cmpb) cmpb_q <= pwdata[15:0];
      if (wr & hit_mask) mask_q <= pwdata[2:0];
      if (psel && !penable) rdata_q <= {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= DIV_RST;
      cnt_q <= WORD_RST;
      dir_up_q <= 1'b1;
      sync_pend_q <= 1'b0;
      sync_out_q <= 1'b0;
      int_q <= INT_RST;
      status_q <= WORD_RST;
    end else begin
      div_q <= tick ? DIV_RST : div_q + 6'h01;
      cnt_q <= cnt_d;
      dir_up_q <= dir_up_d;
      sync_pend_q <= (sync_pend_q & !tick) | sync_evt;
      sync_out_q <= sync_out_d;
      int_q <= int_d;
      status_q[1] <= (status_q[1] & !(wr_sts & pwdata[1])) | sync_evt;
    end
  end

  // Period shadow and active copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prd_sh_q <= PERIOD_RST;
      prd_act_q <= PERIOD_RST;
    end else begin
      if (wr_prd) prd_sh_q <= pwdata[15:0];
      if (wr_prd && ctrl_q.period_load_select) begin
        prd_act_q <= pwdata[15:0];
      end else if (tick && cnt_q == 16'h0000) begin
        prd_act_q <= prd_sh_q;
      end
    end
  end

  assign sync_out_pulse = sync_out_q;
  assign zero_match_event = cnt_q == 16'h0000;
  assign period_match_event = cnt_q == prd_act_q;
  assign compare_b_match_event = cnt_q == cmpb_q;
  assign count_dir_up = dir_up_q;
  assign irq = |(int_q & mask_q);

  AST_ZERO_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    zero_hit |=> int_q[INT_ZERO] && zero_match_event)
    else $error("zero flag not set");
  AST_PRD_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    prd_hit |=> int_q[INT_PERIOD] && period_match_event)
    else $error("period flag not set");
  AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_int && pwdata[0] && !zero_hit) |=> !int_q[INT_ZERO])
    else $error("zero flag not cleared");
  AST_COUNT_UP: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && ctrl_q.count_direction_mode == MODE_UP && cnt_q != prd_act_q
     && !sync_pend_q && !wr_cnt) |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("up count wrong");
  AST_COUNT_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && ctrl_q.count_direction_mode == MODE_DOWN && cnt_q == 16'h0000
     && !sync_pend_q && !wr_cnt) |=> cnt_q == $past(prd_act_q))
    else $error("down wrap wrong");
  AST_PRESCALE: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && ctrl_q.prescale == 6'h01 && !wr_ctl) |=> !tick ##1 tick)
    else $error("prescale spacing wrong");
  AST_PHASE_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (load_phase && !wr_cnt) |=> cnt_q == $past(phase_q))
    else $error("phase not loaded");
  AST_SHADOW: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && cnt_q == 16'h0000 && !wr_prd) |=> prd_act_q == $past(prd_sh_q))
    else $error("shadow not transferred");
  AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && hit_res) |=> rdata_q == 32'h0000_0000)
    else $error("reserved location not zero");
  AST_SYNC_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.sync_out_source_select == SYNCO_PASS && sync_in_pulse && !wr_ctl)
    |=> sync_out_pulse)
    else $error("sync not passed through");
  AST_SYNC_IGNORE: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q.phase_load_enable && !sync_pend_q && tick) |=> !sync_pend_q)
    else $error("ignored sync accepted");

  // Counter, prescaler, sync, period and reserved-location checks
  AST_SYNC_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.sync_out_source_select == SYNCO_ZERO && zero_hit) |=> sync_out_pulse)
    else $error("zero sync out missing");
  AST_SYNC_CMPB: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.sync_out_source_select == SYNCO_CMPB && cmpb_hit) |=> sync_out_pulse)
    else $error("compare sync out missing");
  AST_SYNC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q.sync_out_source_select == SYNCO_OFF |=> !sync_out_pulse)
    else $error("sync out while disabled");
  AST_UPDOWN_TOP: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && ctrl_q.count_direction_mode == MODE_UPDOWN && dir_up_q && cnt_q == prd_act_q
     && !sync_pend_q && !wr_cnt) |=> !count_dir_up && cnt_q == $past(cnt_q) - 16'h0001)
    else $error("up-down top turn wrong");
  AST_UPDOWN_BOTTOM: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && ctrl_q.count_direction_mode == MODE_UPDOWN && !dir_up_q && cnt_q == 16'h0000
     && !sync_pend_q && !wr_cnt) |=> count_dir_up && cnt_q == 16'h0001)
    else $error("up-down bottom turn wrong");
  AST_FREEZE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && freeze && !sync_pend_q && !wr_cnt) |=> $stable(cnt_q))
    else $error("frozen counter moved");
  AST_IDLE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!tick && !wr_cnt) |=> $stable(cnt_q))
    else $error("counter moved between ticks");
  AST_DIV_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> div_q == DIV_RST)
    else $error("prescaler not restarted");
  AST_SYNC_ACCEPT: assert property (@(posedge pclk) disable iff (!presetn)
    sync_evt |=> sync_pend_q && int_q[INT_SYNC] && status_q[1])
    else $error("accepted sync not recorded");
  AST_SYNC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_int && pwdata[INT_SYNC] && !sync_evt) |=> !int_q[INT_SYNC])
    else $error("sync flag not cleared");
  AST_PRD_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_int && pwdata[INT_PERIOD] && !prd_hit) |=> !int_q[INT_PERIOD])
    else $error("period flag not cleared");
  AST_PRD_IMMEDIATE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_prd && ctrl_q.period_load_select) |=> prd_act_q == $past(pwdata[15:0]))
    else $error("immediate period not loaded");
  AST_PRD_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_prd && !ctrl_q.period_load_select && !(tick && cnt_q == 16'h0000))
    |=> $stable(prd_act_q))
    else $error("shadowed period applied early");
  AST_RESERVED_OK: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && hit_res) |-> !pslverr)
    else $error("reserved location errored");

endmodule

// ==== tb/ptb_sync_neighbor.sv ====
/*
  Neighbour modules of the sync chain: upstream pulse source, downstream listener.
  Assumes the pclk domain and one-cycle active-high sync pulses both ways.
*/
`timescale 1ns/1ps
module ptb_sync_neighbor (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic fire, // Bench request, one pulse per rise
  input wire logic sync_from_dut, // Downstream sync seen
  output logic sync_to_dut, // Upstream sync pulse
  output logic [7:0] seen_cnt // Pulses received
);
  logic fire_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fire_q <= 1'b0;
      sync_to_dut <= 1'b0;
      seen_cnt <= 8'h00;
    end else begin
      fire_q <= fire;
      // Single cycle only, as a real upstream module gives
      sync_to_dut <= fire & ~fire_q;
      seen_cnt <= seen_cnt + {7'h00, sync_from_dut};
    end
  end
endmodule

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the time-base counter over APB.
  Assumes the fine-phase extension is absent in this instance.
*/
`timescale 1ns/1ps
module tb_top import ptb_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic sync_in, sync_out, zm, pm, cbm, dir, irq, fire;
  logic [7:0] paddr, seen, s0;
  logic [31:0] pwdata, prdata, rd;
  int failures, checks_done, z, p, n;

  ptb_time_base #(.HAS_FINE_EXT(1'b0)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_in_pulse(sync_in), .sync_out_pulse(sync_out),
    .zero_match_event(zm), .period_match_event(pm), .compare_b_match_event(cbm),
    .count_dir_up(dir), .irq(irq));
  ptb_sync_neighbor nb_u (.pclk(pclk), .presetn(presetn), .fire(fire),
    .sync_from_dut(sync_out), .sync_to_dut(sync_in), .seen_cnt(seen));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic results();
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) failures++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctl(input logic [1:0] md, input logic [1:0] so, input logic ph,
                     input logic [5:0] dv);
    apb(1'b1, IDX_CONTROL, {3'h0, dv, 1'b0, so, 1'b1, ph, md});
    repeat (8) @(posedge pclk);
  endtask

  task automatic evc(input int cyc);
    z = 0;
    p = 0;
    repeat (cyc) begin
      @(negedge pclk);
      z += int'(zm);
      p += int'(pm);
    end
  endtask

  task automatic t_reset();
    apb(1'b0, IDX_CONTROL, 16'h0000);
    chk("control", 32'h0000_0003, rd);
    apb(1'b0, 8'h3F, 16'h0000);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b1, IDX_FINE, 16'h1234);
    apb(1'b0, IDX_FINE, 16'h0000);
    chk("fine phase", 32'h0, rd);
    chk("fine err", 32'h0, {31'h0, er});
  endtask

  task automatic t_modes();
    apb(1'b1, IDX_PERIOD, 16'h0003);
    ctl(2'h0, 2'h3, 1'b0, 6'h00);
    evc(8);
    chk("up zero", 32'h2, z);
    chk("up period", 32'h2, p);
    ctl(2'h1, 2'h3, 1'b0, 6'h00);
    evc(8);
    chk("down zero", 32'h2, z);
    chk("down dir", 32'h0, {31'h0, dir});
    ctl(2'h2, 2'h3, 1'b0, 6'h00);
    evc(12);
    chk("updown period", 32'h2, p);
    ctl(2'h0, 2'h3, 1'b0, 6'h01);
    evc(16);
    chk("div2 zero", 32'h4, z);
  endtask

  task automatic t_irq();
    ctl(2'h3, 2'h3, 1'b0, 6'h00);
    apb(1'b1, IDX_INT_STATUS, 16'h0007);
    apb(1'b0, IDX_INT_STATUS, 16'h0000);
    chk("flags cleared", 32'h0, rd);
    apb(1'b1, IDX_INT_MASK, 16'h0001);
    ctl(2'h0, 2'h3, 1'b0, 6'h00);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, IDX_INT_MASK, 16'h0000);
    @(negedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
  endtask

  task automatic t_syncout();
    apb(1'b1, IDX_CMPB, 16'h0001);
    for (int s = 1; s < 4; s++) begin
      ctl(2'h0, 2'(s), 1'b0, 6'h00);
      s0 = seen;
      repeat (16) @(posedge pclk);
      chk("sync out count", (s == 3) ? 32'h0 : 32'h4, {24'h0, seen - s0});
    end
    ctl(2'h0, 2'h0, 1'b0, 6'h00);
    s0 = seen;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("sync pass", 32'h1, {24'h0, seen - s0});
  endtask

  task automatic t_phase(input logic ph);
    apb(1'b1, IDX_PHASE, 16'h0002);
    ctl(2'h0, 2'h3, ph, 6'h3F);
    apb(1'b1, IDX_INT_STATUS, 16'h0007);
    n = 0;
    while (zm !== 1'b0 && n < 300) begin
      n++;
      @(negedge pclk);
    end
    while (zm !== 1'b1 && n < 600) begin
      n++;
      @(negedge pclk);
    end
    if (n >= 600) failures++;
    // Sync lands mid-tick, so the load waits for the next tick
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (70) @(posedge pclk);
    apb(1'b0, IDX_COUNT, 16'h0000);
    chk("counter", ph ? 32'h2 : 32'h1, rd);
    apb(1'b0, IDX_INT_STATUS, 16'h0000);
    chk("sync flag", {31'h0, ph}, {31'h0, rd[INT_SYNC]});
  endtask

  task automatic t_swsync();
    ctl(2'h3, 2'h3, 1'b1, 6'h00);
    apb(1'b1, IDX_STATUS, 16'h0002);
    apb(1'b1, IDX_CONTROL, 16'h007F);
    repeat (2) @(posedge pclk);
    apb(1'b0, IDX_COUNT, 16'h0000);
    chk("sw sync load", 32'h2, rd);
    apb(1'b0, IDX_STATUS, 16'h0000);
    chk("status", 32'h3, rd);
    apb(1'b0, IDX_INT_STATUS, 16'h0000);
    chk("sw sync flag", 32'h1, {31'h0, rd[INT_SYNC]});
    apb(1'b1, IDX_COUNT, 16'h0001);
    @(negedge pclk);
    chk("cmpb match", 32'h1, {31'h0, cbm});
  endtask

  initial begin
    failures = 0;
    checks_done = 0;
    {presetn, psel, penable, pwrite, fire} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_irq();
    t_syncout();
    t_phase(1'b1);
    t_phase(1'b0);
    t_swsync();
    results();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    results();
  end
endmodule
